// ===== hdl/fspc_pkg.sv
package fspc_pkg;

  // Instruction codes
  localparam logic [7:0] OPC_WREN     = 8'h06;
  localparam logic [7:0] OPC_WRDI     = 8'h04;
  localparam logic [7:0] OPC_VOLWEN   = 8'h50;
  localparam logic [7:0] OPC_RDSR1    = 8'h05;
  localparam logic [7:0] OPC_RDSR2    = 8'h35;
  localparam logic [7:0] OPC_RDSR3    = 8'h15;
  localparam logic [7:0] OPC_WRSR1    = 8'h01;
  localparam logic [7:0] OPC_WRSR2    = 8'h31;
  localparam logic [7:0] OPC_WRSR3    = 8'h11;
  localparam logic [7:0] OPC_SUSPEND  = 8'h75;
  localparam logic [7:0] OPC_RESUME   = 8'h7A;
  localparam logic [7:0] OPC_ENTQUAD  = 8'h38;
  localparam logic [7:0] OPC_EXITQUAD = 8'hFF;
  localparam logic [7:0] OPC_EN4B     = 8'hB7;
  localparam logic [7:0] OPC_EX4B     = 8'hE9;
  localparam logic [7:0] OPC_PREFIX_A = 8'hAA;
  localparam logic [7:0] OPC_PREFIX_B = 8'h55;

  // Register selectors
  localparam logic [1:0] SEL_FIRST  = 2'h0;
  localparam logic [1:0] SEL_SECOND = 2'h1;
  localparam logic [1:0] SEL_THIRD  = 2'h2;

  // Bit positions inside each status byte
  localparam int BIT_BUSY   = 0;
  localparam int BIT_WEL    = 1;
  localparam int BIT_BP_LO  = 2;
  localparam int BIT_TB     = 6;
  localparam int BIT_SRP    = 7;
  localparam int BIT_SRL    = 0;
  localparam int BIT_QE     = 1;
  localparam int BIT_LB_LO  = 3;
  localparam int BIT_CMP    = 6;
  localparam int BIT_SUS    = 7;
  localparam int BIT_ADS    = 0;
  localparam int BIT_ADP    = 1;
  localparam int BIT_WPS    = 2;
  localparam int BIT_DRV_LO = 5;
  localparam int BIT_HLDRST = 7;

  // Factory defaults
  localparam logic [1:0] DRV_DEFAULT = 2'h3;
  localparam logic       QE_DEFAULT  = 1'b0;

  // Drive strength in percent
  localparam logic [6:0] DRV_PCT_100 = 7'h64;
  localparam logic [6:0] DRV_PCT_75  = 7'h4B;
  localparam logic [6:0] DRV_PCT_50  = 7'h32;
  localparam logic [6:0] DRV_PCT_25  = 7'h19;

  // Status write time
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned WRITE_TIME_NS = 10000;
  localparam int unsigned WRITE_CYCLES  =
    (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          WRITE_CNT_W   = 9;

  typedef struct packed {
    logic       status_protect;
    logic       tb;
    logic [3:0] bp;
    logic       status_lock;
    logic       qe;
    logic [2:0] lock;
    logic       cmp;
    logic       powerup_addr_width;
    logic       protect_scheme_select;
    logic [1:0] drv;
    logic       holdRst;
  } fspc_cfg_t;

  localparam fspc_cfg_t CFG_FACTORY = '{
    status_protect: 1'b0, tb: 1'b0, bp: 4'h0, status_lock: 1'b0, qe: QE_DEFAULT,
    lock: 3'h0, cmp: 1'b0, powerup_addr_width: 1'b0, protect_scheme_select: 1'b0, drv: DRV_DEFAULT,
    holdRst: 1'b0};

endpackage

// ===== hdl/fspc_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface fspc_link_if;
  logic [7:0] rxByte;
  logic       rxStrobe;
  logic       frameStart;
  logic       frameEnd;
  logic [7:0] txByte;
  logic       txEnable;
  logic       holdActive;
  logic       linkReset;

  modport link (output rxByte, output rxStrobe, output frameStart,
                output frameEnd, input txByte, input txEnable,
                input holdActive, input linkReset);
  modport core (input rxByte, input rxStrobe, input frameStart,
                input frameEnd, output txByte, output txEnable,
                output holdActive, output linkReset);
endinterface
`default_nettype wire

// ===== hdl/fspc_busy_timer.sv
`timescale 1ns/100ps
`default_nettype none
module fspc_busy_timer
  import fspc_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic start,
  output logic      busy
);

  typedef struct packed {
    logic [WRITE_CNT_W-1:0] count;
    logic                   busy;
  } fspc_tmr_t;

  fspc_tmr_t state_r;
  fspc_tmr_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (start && !state_r.busy) begin
      state_nxt.busy  = 1'b1;
      state_nxt.count = WRITE_CNT_W'(WRITE_CYCLES - 1);
    end else if (state_r.busy) begin
      if (state_r.count == '0) begin
        state_nxt.busy = 1'b0;
      end else begin
        state_nxt.count = state_r.count - 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign busy = state_r.busy;

endmodule
`default_nettype wire

// ===== hdl/fspc_link_rx.sv
`timescale 1ns/100ps
`default_nettype none
module fspc_link_rx (
  input  wire logic    sys_clk,
  input  wire logic    srst,
  input  wire logic    spiClk,
  input  wire logic    spiCsN,
  input  wire logic    spiDataIn,
  output logic         spiDataOut,
  output logic         spiDataOutEn,
  fspc_link_if.link    lnk
);

  typedef struct packed {
    logic [1:0] clkSync;
    logic [1:0] csSync;
    logic [1:0] dinSync;
    logic       clkPrev;
    logic       csPrev;
    logic [7:0] rxShift;
    logic [2:0] bitCnt;
    logic       reload;
    logic [7:0] txShift;
    logic [7:0] rxByte;
    logic       rxStrobe;
    logic       frameStart;
    logic       frameEnd;
    logic       dout;
    logic       doutEn;
  } fspc_lnk_t;

  fspc_lnk_t state_r;
  fspc_lnk_t state_nxt;
  logic      clkRise;
  logic      clkFall;
  logic      inFrame;

  assign inFrame = !state_r.csSync[1];
  assign clkRise = state_r.clkSync[1] && !state_r.clkPrev;
  assign clkFall = !state_r.clkSync[1] && state_r.clkPrev;

  always_comb begin
    state_nxt            = state_r;
    state_nxt.clkSync    = {state_r.clkSync[0], spiClk};
    state_nxt.csSync     = {state_r.csSync[0], spiCsN};
    state_nxt.dinSync    = {state_r.dinSync[0], spiDataIn};
    state_nxt.clkPrev    = state_r.clkSync[1];
    state_nxt.csPrev     = state_r.csSync[1];
    state_nxt.rxStrobe   = 1'b0;
    state_nxt.frameStart = state_r.csPrev && inFrame;
    state_nxt.frameEnd   = !state_r.csPrev && !inFrame;
    if (!inFrame || lnk.linkReset) begin
      state_nxt.bitCnt = 3'h0;
      state_nxt.reload = 1'b0;
      state_nxt.doutEn = 1'b0;
    end else if (!lnk.holdActive) begin
      // Mode 0: sample on rising, shift out on falling
      if (clkRise) begin
        state_nxt.rxShift = {state_r.rxShift[6:0], state_r.dinSync[1]};
        state_nxt.bitCnt  = state_r.bitCnt + 3'h1;
        if (state_r.bitCnt == 3'h7) begin
          state_nxt.rxByte   = {state_r.rxShift[6:0], state_r.dinSync[1]};
          state_nxt.rxStrobe = 1'b1;
          state_nxt.reload   = 1'b1;
        end
      end
      if (clkFall) begin
        // Core answer is settled half a link period after the byte
        if (state_r.reload) begin
          state_nxt.txShift = lnk.txByte;
          state_nxt.reload  = 1'b0;
        end else begin
          state_nxt.txShift = {state_r.txShift[6:0], 1'b0};
        end
        state_nxt.dout   = state_r.reload ? lnk.txByte[7]
                                          : state_r.txShift[6];
        state_nxt.doutEn = lnk.txEnable;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_r         <= '0;
      state_r.clkPrev <= 1'b0;
      state_r.csSync  <= 2'h3;
      state_r.csPrev  <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign lnk.rxByte     = state_r.rxByte;
  assign lnk.rxStrobe   = state_r.rxStrobe;
  assign lnk.frameStart = state_r.frameStart;
  assign lnk.frameEnd   = state_r.frameEnd;
  assign spiDataOut     = state_r.dout;
  assign spiDataOutEn   = state_r.doutEn;

endmodule
`default_nettype wire

// ===== hdl/fspc_status_cfg.sv
// Function
// - Complement bit kept, reads back, default zero
// - Complement set inverts the selected protected region while scheme bit is clear
// - Status-protect bit picks software or pin protection
// - Lock bit picks temporary or permanent lock
// - Both clear: pin ignored, latch enables writes
// - Protect set, pin low: status writes rejected
// - Protect set, pin high: writes need latch
// - Lock set blocks writes until power cycle; a lock set by volatile write only until pin reset
// - Two-byte prefix plus lock write locks until power cycle
// - Suspend flag set by suspend, cleared resume
// - Three security locks, settable once, cleared only by power cycle
// - Quad enable frees pins, disables hold and pin
// - Four-wire mode entry needs quad enable set
// - Four-wire mode keeps quad enable at one
// - Current address width flag is read-only
// - Power-up width written only by non-volatile write
// - Power-up width bit picks start address mode
// - Scheme bit picks range bits or block locks
// - All block locks set at every reset
// - Two-bit drive field decodes to four strengths
// - Shared pin is hold or reset when quad off
// - Reserved bits read zero, writes ignored
// - Status write needs latch or volatile enable; latch cleared after
// - Busy flag during non-volatile writes; most commands ignored
`timescale 1ns/100ps
`default_nettype none
module fspc_status_cfg
  import fspc_pkg::*;
(
  input  wire logic  sys_clk,
  input  wire logic  srst,
  input  wire logic  spiClk,
  input  wire logic  spiCsN,
  input  wire logic  spiDataIn,
  input  wire logic  wpPinN,
  input  wire logic  holdRstPinN,
  output logic       spiDataOut,
  output logic       spiDataOutEn,
  output logic       busy,
  output logic       writeEnableLatch,
  output logic       suspendFlag,
  output logic       complementProtect,
  output logic       topBottomSelect,
  output logic [3:0] blockProtect,
  output logic       protectInvert,
  output logic       protectSchemeSelect,
  output logic       blockLocksAll,
  output logic [2:0] securityLocks,
  output logic       quadEnable,
  output logic       fourWireCommandMode,
  output logic       currentAddrWidth,
  output logic [6:0] driveStrengthPct,
  output logic       holdActive,
  output logic       pinResetActive
);

  typedef enum logic [1:0] {
    PH_OPCODE = 2'b00,
    PH_DATA   = 2'b01,
    PH_READ   = 2'b11,
    PH_IGNORE = 2'b10
  } fspc_phase_t;

  typedef struct packed {
    logic [1:0]  wpSync;
    logic [1:0]  hrSync;
    fspc_cfg_t   nv;
    fspc_cfg_t   vol;
    logic        write_enable_latch;
    logic        volWen;
    logic        suspend_flag;
    logic        quadCmd;
    logic        current_addr_width;
    logic        otp;
    logic        prefA;
    logic        prefB;
    logic        locksAll;
    fspc_phase_t ph;
    logic [7:0]  opc;
    logic [1:0]  sel;
    logic [7:0]  data;
    logic        haveData;
    logic        startWrite;
    logic        protInv;
    logic [6:0]  drvPct;
    logic        hold;
    logic        pinRst;
  } fspc_core_t;

  fspc_core_t     state_r;
  fspc_core_t     state_nxt;
  logic           busyNow;
  logic           writeOk;
  logic           wpBlocks;
  fspc_cfg_t      written;
  fspc_link_if    lnk ();

  function automatic logic [7:0] statusByte(input fspc_core_t s,
                                            input logic [1:0] sel,
                                            input logic bsy);
    logic [7:0] b;
    b = 8'h00;
    unique case (sel)
      SEL_FIRST: begin
        b[BIT_BUSY]            = bsy;
        b[BIT_WEL]             = s.write_enable_latch;
        b[BIT_BP_LO +: 4]      = s.vol.bp;
        b[BIT_TB]              = s.vol.tb;
        b[BIT_SRP]             = s.vol.status_protect;
      end
      SEL_SECOND: begin
        b[BIT_SRL]             = s.vol.status_lock;
        b[BIT_QE]              = s.vol.qe;
        b[BIT_LB_LO +: 3]      = s.vol.lock;
        b[BIT_CMP]             = s.vol.cmp;
        b[BIT_SUS]             = s.suspend_flag;
      end
      default: begin
        b[BIT_ADS]             = s.current_addr_width;
        b[BIT_ADP]             = s.vol.powerup_addr_width;
        b[BIT_WPS]             = s.vol.protect_scheme_select;
        b[BIT_DRV_LO +: 2]     = s.vol.drv;
        b[BIT_HLDRST]          = s.vol.holdRst;
      end
    endcase
    return b;
  endfunction

  function automatic fspc_cfg_t applyWrite(input fspc_cfg_t c,
                                           input logic [1:0] sel,
                                           input logic [7:0] d,
                                           input logic quadMode);
    fspc_cfg_t n;
    n = c;
    unique case (sel)
      SEL_FIRST: begin
        n.bp  = d[BIT_BP_LO +: 4];
        n.tb  = d[BIT_TB];
        n.status_protect = d[BIT_SRP];
      end
      SEL_SECOND: begin
        n.status_lock  = d[BIT_SRL];
        n.qe   = d[BIT_QE] | (quadMode & c.qe);
        n.lock = c.lock | d[BIT_LB_LO +: 3];
        n.cmp  = d[BIT_CMP];
      end
      default: begin
        n.powerup_addr_width     = d[BIT_ADP];
        n.protect_scheme_select     = d[BIT_WPS];
        n.drv     = d[BIT_DRV_LO +: 2];
        n.holdRst = d[BIT_HLDRST];
      end
    endcase
    return n;
  endfunction

  function automatic logic [6:0] drivePct(input logic [1:0] drv);
    logic [6:0] p;
    p = DRV_PCT_25;
    unique case (drv)
      2'h0:    p = DRV_PCT_100;
      2'h1:    p = DRV_PCT_75;
      2'h2:    p = DRV_PCT_50;
      default: p = DRV_PCT_25;
    endcase
    return p;
  endfunction

  fspc_link_rx u_link (
    .sys_clk      (sys_clk),
    .srst         (srst),
    .spiClk       (spiClk),
    .spiCsN       (spiCsN),
    .spiDataIn    (spiDataIn),
    .spiDataOut   (spiDataOut),
    .spiDataOutEn (spiDataOutEn),
    .lnk          (lnk.link)
  );

  fspc_busy_timer u_timer (
    .sys_clk (sys_clk),
    .srst    (srst),
    .start   (state_r.startWrite),
    .busy    (busyNow)
  );

  // pin has no say once quad is on
  assign wpBlocks = state_r.vol.status_protect && !state_r.wpSync[1] &&
                    !state_r.vol.qe;
  // software mode needs only the latch
  // pin high unlocks behind the latch
  // lock bit blocks until power cycle, or until pin reset if set by volatile write
  assign writeOk  = !state_r.vol.status_lock && !state_r.otp && !wpBlocks &&
                    !busyNow;
  assign written  = applyWrite(state_r.vol, state_r.sel, state_r.data,
                               state_r.quadCmd);

  assign lnk.txByte     = statusByte(state_r, state_r.sel, busyNow);
  assign lnk.txEnable   = state_r.ph == PH_READ;
  assign lnk.holdActive = state_r.hold;
  assign lnk.linkReset  = state_r.pinRst;

  always_comb begin
    state_nxt            = state_r;
    state_nxt.wpSync     = {state_r.wpSync[0], wpPinN};
    state_nxt.hrSync     = {state_r.hrSync[0], holdRstPinN};
    state_nxt.startWrite = 1'b0;
    // hold or reset only with quad off
    state_nxt.hold   = !state_r.vol.qe && !state_r.vol.holdRst &&
                       !state_r.hrSync[1];
    state_nxt.pinRst = !state_r.vol.qe && state_r.vol.holdRst &&
                       !state_r.hrSync[1];
    if (state_r.pinRst) begin
      // volatile copies reload from stored values
      state_nxt.vol      = state_r.nv;
      state_nxt.write_enable_latch      = 1'b0;
      state_nxt.volWen   = 1'b0;
      state_nxt.suspend_flag      = 1'b0;
      state_nxt.quadCmd  = 1'b0;
      state_nxt.current_addr_width      = state_r.nv.powerup_addr_width;
      state_nxt.locksAll = 1'b1;
      state_nxt.ph       = PH_OPCODE;
      state_nxt.prefA    = 1'b0;
      state_nxt.prefB    = 1'b0;
    end else if (lnk.frameStart) begin
      state_nxt.ph       = PH_OPCODE;
      state_nxt.haveData = 1'b0;
    end else if (lnk.rxStrobe) begin
      unique case (state_r.ph)
        PH_OPCODE: begin
          state_nxt.opc = lnk.rxByte;
          state_nxt.ph  = PH_IGNORE;
          if (lnk.rxByte == OPC_RDSR1 || lnk.rxByte == OPC_RDSR2 ||
              lnk.rxByte == OPC_RDSR3) begin
            state_nxt.ph  = PH_READ;
            state_nxt.sel = lnk.rxByte == OPC_RDSR1 ? SEL_FIRST :
                            lnk.rxByte == OPC_RDSR2 ? SEL_SECOND :
                                                      SEL_THIRD;
          end else if (lnk.rxByte == OPC_SUSPEND) begin
            // suspend sets flag, even while busy
            state_nxt.suspend_flag = 1'b1;
          end else if (!busyNow) begin
            // the rest is ignored while busy
            unique case (lnk.rxByte)
              OPC_WREN:     state_nxt.write_enable_latch = 1'b1;
              OPC_WRDI:     state_nxt.write_enable_latch = 1'b0;
              OPC_VOLWEN:   state_nxt.volWen = 1'b1;
              OPC_RESUME:   state_nxt.suspend_flag = 1'b0;
              OPC_ENTQUAD:  state_nxt.quadCmd = state_r.vol.qe;
              OPC_EXITQUAD: state_nxt.quadCmd = 1'b0;
              OPC_EN4B:     state_nxt.current_addr_width = 1'b1;
              OPC_EX4B:     state_nxt.current_addr_width = 1'b0;
              OPC_WRSR1, OPC_WRSR2, OPC_WRSR3: begin
                state_nxt.ph  = PH_DATA;
                state_nxt.sel = lnk.rxByte == OPC_WRSR1 ? SEL_FIRST :
                                lnk.rxByte == OPC_WRSR2 ? SEL_SECOND :
                                                          SEL_THIRD;
              end
              default: state_nxt.ph = PH_IGNORE;
            endcase
          end
        end
        PH_DATA: begin
          state_nxt.data     = lnk.rxByte;
          state_nxt.haveData = 1'b1;
          state_nxt.ph       = PH_IGNORE;
        end
        PH_READ:   state_nxt.ph = PH_READ;
        PH_IGNORE: state_nxt.ph = PH_IGNORE;
      endcase
    end else if (lnk.frameEnd) begin
      state_nxt.ph    = PH_OPCODE;
      // prefix pair must lead the write
      state_nxt.prefA = state_r.opc == OPC_PREFIX_A;
      state_nxt.prefB = state_r.prefA && state_r.opc == OPC_PREFIX_B;
      if (state_r.haveData && writeOk) begin
        // non-volatile write needs latch, then clears it
        if (state_r.write_enable_latch) begin
          state_nxt.nv         = written;
          state_nxt.vol        = written;
          state_nxt.write_enable_latch        = 1'b0;
          state_nxt.volWen     = 1'b0;
          state_nxt.startWrite = 1'b1;
          if (state_r.prefB && written.status_lock) begin
            state_nxt.otp = 1'b1;
          end
        end else if (state_r.volWen) begin
          // power-up width untouched by volatile writes
          state_nxt.vol     = written;
          state_nxt.vol.powerup_addr_width = state_r.vol.powerup_addr_width;
          // one-time locks only through the stored path
          state_nxt.vol.lock = state_r.vol.lock;
          state_nxt.volWen  = 1'b0;
          state_nxt.nv.status_lock  = state_r.nv.status_lock;
        end
      end
    end
    // quad enable pinned in four-wire mode
    if (state_r.quadCmd) begin
      state_nxt.vol.qe = 1'b1;
    end
    state_nxt.protInv = state_r.vol.cmp && !state_r.vol.protect_scheme_select;
    state_nxt.drvPct  = drivePct(state_r.vol.drv);
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      // power cycle returns lock to zero
      state_r          <= '0;
      state_r.wpSync   <= 2'h3;
      state_r.hrSync   <= 2'h3;
      state_r.nv       <= CFG_FACTORY;
      state_r.vol      <= CFG_FACTORY;
      state_r.locksAll <= 1'b1;
      state_r.ph       <= PH_OPCODE;
      state_r.drvPct   <= DRV_PCT_25;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Busy is the timer's own flop
  assign busy                = busyNow;
  assign writeEnableLatch    = state_r.write_enable_latch;
  assign suspendFlag         = state_r.suspend_flag;
  // protect bit exposed for array logic
  assign complementProtect   = state_r.vol.cmp;
  assign topBottomSelect     = state_r.vol.tb;
  assign blockProtect        = state_r.vol.bp;
  assign protectInvert       = state_r.protInv;
  assign protectSchemeSelect = state_r.vol.protect_scheme_select;
  assign blockLocksAll       = state_r.locksAll;
  assign securityLocks       = state_r.vol.lock;
  assign quadEnable          = state_r.vol.qe;
  assign fourWireCommandMode = state_r.quadCmd;
  assign currentAddrWidth    = state_r.current_addr_width;
  assign driveStrengthPct    = state_r.drvPct;
  assign holdActive          = state_r.hold;
  assign pinResetActive      = state_r.pinRst;

endmodule
`default_nettype wire

// ===== hdl/fspc_unused_placeholder_none.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ===== dv/fspc_status_cfg_properties.sv
`timescale 1ns/100ps
`default_nettype none
module fspc_status_cfg_checker
  import fspc_pkg::*;
(
  input wire logic       sys_clk,
  input wire logic       srst,
  input wire logic       busy,
  input wire logic       writeEnableLatch,
  input wire logic       complementProtect,
  input wire logic       protectInvert,
  input wire logic       protectSchemeSelect,
  input wire logic       blockLocksAll,
  input wire logic [2:0] securityLocks,
  input wire logic       quadEnable,
  input wire logic       fourWireCommandMode,
  input wire logic       holdActive,
  input wire logic       pinResetActive
);
  logic [8:0] busyCnt_r;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  always_ff @(posedge sys_clk)
    busyCnt_r <= busy ? busyCnt_r + 9'h001 : 9'h000;
  property p_busyLen;
    $fell(busy) && !$past(srst) |-> busyCnt_r == 9'(WRITE_CYCLES);
  endproperty
  a_busyLen: assert property (p_busyLen) else $error("busy length");
  property p_latchClr;
    $rose(busy) |-> ##[0:3] !writeEnableLatch;
  endproperty
  a_latchClr: assert property (p_latchClr) else $error("latch kept");
  property p_invert;
    $stable(complementProtect) && $stable(protectSchemeSelect)
      |-> protectInvert == (complementProtect && !protectSchemeSelect);
  endproperty
  a_invert: assert property (p_invert) else $error("invert wrong");
  property p_quadPins;
    quadEnable && $past(quadEnable) |-> !holdActive && !pinResetActive;
  endproperty
  a_quadPins: assert property (p_quadPins) else $error("pin active");
  property p_quadKeep;
    fourWireCommandMode |-> quadEnable;
  endproperty
  a_quadKeep: assert property (p_quadKeep) else $error("quad lost");
  property p_quadEntry;
    $rose(fourWireCommandMode) |-> $past(quadEnable);
  endproperty
  a_quadEntry: assert property (p_quadEntry) else $error("entry");
  property p_otp;
    !$past(srst) |-> (securityLocks & $past(securityLocks))
      == $past(securityLocks);
  endproperty
  a_otp: assert property (p_otp) else $error("lock cleared");
  property p_resetLocks;
    $fell(srst) |-> blockLocksAll;
  endproperty
  a_resetLocks: assert property (p_resetLocks) else $error("locks");
endmodule
`default_nettype wire

// ===== dv/fspc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module fspc_host_model (
  output logic      spiClk,
  output logic      spiCsN,
  output logic      spiDataIn,
  input  wire logic spiDataOut
);
  initial begin
    spiClk = 1'b0;
    spiCsN = 1'b1;
    spiDataIn = 1'b0;
  end
  // Mode 0; clock stands low between frames
  task automatic frame(input logic [7:0] op, input logic [7:0] d,
                       input logic two, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {op, d};
    rd = 8'h00;
    #37 spiCsN = 1'b0;
    for (int i = 0; i < (two ? 16 : 8); i++) begin
      spiDataIn = sh[15-i];
      #160 spiClk = 1'b1;
      #150 rd = {rd[6:0], spiDataOut};
      #10 spiClk = 1'b0;
    end
    #160 spiCsN = 1'b1;
    // Released line has no pull
    spiDataIn = ~spiDataIn;
    #400;
  endtask
endmodule
`default_nettype wire

// ===== dv/fspc_status_cfg_test.sv
`timescale 1ns/100ps
`default_nettype none
module fspc_status_cfg_test;
  import fspc_pkg::*;
  logic       sys_clk, srst, wpPinN, holdRstPinN, spiClk, spiCsN;
  logic       spiDataIn, spiDataOut, spiDataOutEn, busy, suspendFlag;
  logic       writeEnableLatch, complementProtect, topBottomSelect;
  logic       protectInvert, protectSchemeSelect, blockLocksAll;
  logic       quadEnable, fourWireCommandMode, currentAddrWidth;
  logic       holdActive, pinResetActive;
  logic [3:0] blockProtect;
  logic [2:0] securityLocks;
  logic [6:0] driveStrengthPct;
  logic [7:0] rd;
  int         num_errors, comparisons, cycles;
  fspc_status_cfg dut (.*);
  fspc_host_model u_host (.*);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chb(string nm, logic e, logic g);
    chk(nm, {7'h0, e}, {7'h0, g});
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(logic [7:0] op, logic [7:0] d);
    u_host.frame(OPC_WREN, 8'h00, 1'b0, rd);
    u_host.frame(op, d, 1'b1, rd);
    for (int i = 0; i < 400 && busy !== 1'b0; i++) tick(1);
    tick(1);
  endtask
  task automatic t_protect();
    wr(OPC_WRSR1, 8'h80);
    u_host.frame(OPC_RDSR1, 8'h00, 1'b1, rd);
    chk("first", 8'h80, rd);
    chb("oeOff", 1'b0, spiDataOutEn);
    tick(1);
    wpPinN = 1'b0;
    wr(OPC_WRSR1, 8'h84);
    chk("bpLow", 8'h00, {4'h0, blockProtect});
    wpPinN = 1'b1;
    wr(OPC_WRSR1, 8'h04);
    chk("bpHigh", 8'h01, {4'h0, blockProtect});
    wpPinN = 1'b0;
    wr(OPC_WRSR1, 8'h48);
    chk("bpSoft", 8'h02, {4'h0, blockProtect});
    chb("tb", 1'b1, topBottomSelect);
    wpPinN = 1'b1;
  endtask
  task automatic t_quad();
    u_host.frame(OPC_ENTQUAD, 8'h00, 1'b0, rd);
    chb("fwOff", 1'b0, fourWireCommandMode);
    wr(OPC_WRSR2, 8'h02);
    u_host.frame(OPC_ENTQUAD, 8'h00, 1'b0, rd);
    chb("fwOn", 1'b1, fourWireCommandMode);
    wr(OPC_WRSR2, 8'h00);
    chb("qeKept", 1'b1, quadEnable);
    u_host.frame(OPC_EXITQUAD, 8'h00, 1'b0, rd);
  endtask
  task automatic t_second();
    u_host.frame(OPC_WREN, 8'h00, 1'b0, rd);
    u_host.frame(OPC_WRDI, 8'h00, 1'b0, rd);
    u_host.frame(OPC_WRSR2, 8'h40, 1'b1, rd);
    tick(300);
    chb("noLatch", 1'b0, complementProtect);
    wr(OPC_WRSR2, 8'h4A);
    chb("inv", 1'b1, protectInvert);
    chb("wel", 1'b0, writeEnableLatch);
    chk("sec", 8'h01, {5'h0, securityLocks});
    wr(OPC_WRSR2, 8'h42);
    u_host.frame(OPC_RDSR2, 8'h00, 1'b1, rd);
    chk("second", 8'h4A, rd);
  endtask
  task automatic t_drive();
    logic [6:0] p [4] = '{DRV_PCT_100, DRV_PCT_75, DRV_PCT_50, DRV_PCT_25};
    for (int c = 0; c < 4; c++) begin
      wr(OPC_WRSR3, {1'b0, c[1:0], 5'h04});
      chk("pct", {1'b0, p[c]}, {1'b0, driveStrengthPct});
      chb("invOff", 1'b0, protectInvert);
      chb("wps", 1'b1, protectSchemeSelect);
    end
  endtask
  task automatic t_pins();
    wr(OPC_WRSR2, 8'h40);
    holdRstPinN = 1'b0;
    tick(5);
    chb("hold", 1'b1, holdActive);
    holdRstPinN = 1'b1;
    wr(OPC_WRSR3, 8'hE2);
    chb("addrKeep", 1'b0, currentAddrWidth);
    holdRstPinN = 1'b0;
    tick(5);
    chb("pinRst", 1'b1, pinResetActive);
    holdRstPinN = 1'b1;
    tick(5);
    chb("addrUp", 1'b1, currentAddrWidth);
    chb("cmplKept", 1'b1, complementProtect);
    // Volatile write must leave the power-up width alone
    u_host.frame(OPC_VOLWEN, 8'h00, 1'b0, rd);
    u_host.frame(OPC_WRSR3, 8'hE0, 1'b1, rd);
    u_host.frame(OPC_RDSR3, 8'h00, 1'b1, rd);
    chk("volAdp", 8'hE3, rd);
    u_host.frame(OPC_EX4B, 8'h00, 1'b0, rd);
    chb("ads3", 1'b0, currentAddrWidth);
  endtask
  task automatic t_suspend_lock();
    u_host.frame(OPC_SUSPEND, 8'h00, 1'b0, rd);
    chb("susSet", 1'b1, suspendFlag);
    u_host.frame(OPC_RESUME, 8'h00, 1'b0, rd);
    chb("susClr", 1'b0, suspendFlag);
    wr(OPC_WRSR2, 8'h41);
    wr(OPC_WRSR2, 8'h00);
    chb("locked", 1'b1, complementProtect);
    srst = 1'b1;
    tick(20);
    srst = 1'b0;
    tick(4);
    chb("cmplDef", 1'b0, complementProtect);
    wr(OPC_WRSR2, 8'h40);
    chb("unlocked", 1'b1, complementProtect);
  endtask
  initial begin
    srst = 1'b1;
    wpPinN = 1'b1;
    holdRstPinN = 1'b1;
    num_errors = 0;
    comparisons = 0;
    cycles = 0;
    tick(20);
    srst = 1'b0;
    tick(4);
    u_host.frame(OPC_RDSR3, 8'h00, 1'b1, rd);
    chk("third", 8'h60, rd);
    chb("allLocks", 1'b1, blockLocksAll);
    t_protect();
    t_quad();
    t_second();
    t_drive();
    t_pins();
    t_suspend_lock();
    report_and_stop();
  end
endmodule
bind fspc_status_cfg fspc_status_cfg_checker u_chk (.*);
`default_nettype wire
